// [rtl/spp_map.vh]
`ifndef SPP_MAP_VH
`define SPP_MAP_VH
`define SPP_NPORTS          24
`define SPP_HALF            12
// Register byte offsets.
`define SPP_OFF_ADMIN       8'h00
`define SPP_OFF_ANEG        8'h04
`define SPP_OFF_FC          8'h08
`define SPP_OFF_STORM_EN    8'h0c
`define SPP_OFF_THRESH      8'h10
`define SPP_OFF_SEC_EN      8'h14
`define SPP_OFF_ACTION      8'h18
`define SPP_OFF_MIRROR      8'h1c
`define SPP_OFF_STATUS      8'h20
`define SPP_OFF_INTRUDE     8'h24
`define SPP_OFF_TRUNK       8'h28
`define SPP_OFF_LACP        8'h2c
`define SPP_OFF_PCFG_BASE   8'h40
// Per-port config word: [4:0] advert, [6:5] speed, [7] duplex, [8] sym.
`define SPP_ADV_LSB         0
`define SPP_ADV_MSB         4
`define SPP_SPD_LSB         5
`define SPP_SPD_MSB         6
`define SPP_DPX_BIT         7
`define SPP_SYM_BIT         8
`define SPP_ADV_MASK        5'h1f
`define SPP_ADV_COPPER_GIG  5'h1f
`define SPP_ADV_COPPER_100  5'h0f
`define SPP_ADV_FIBRE_GIG   5'h10
`define SPP_ADV_FULL1000    5'h10
`define SPP_THR_MIN         18'h001f4
`define SPP_THR_MAX         18'h3ffff
`define SPP_THR_RST         18'h001f4
// Rate window: one second at 20 MHz.
`define SPP_CLK_HZ          20000000
`define SPP_WINDOW_MS       1000
`define SPP_WINDOW_CYC      (`SPP_CLK_HZ / 1000 * `SPP_WINDOW_MS)
// Mirror word: [4:0] src, [9:5] dst, [10] rx, [11] tx, [12] enable.
`define SPP_MIR_EN_BIT      12
`define SPP_SPD_1000        2'h2
`endif

// [rtl/spp_port_policy.v]
// Summary of operation
// - Advertisement offers only 10/100 half/full and 1000 full, never 1000 half.
// - Reset: autonegotiation on; advertisement per port type copper/fibre/100.
// - Forced speed, duplex, flow control apply only with negotiation off.
// - Flow control: jam in half duplex, pause frames in full duplex; at 1000 the code sends pause only with sym set.
// - Pause is symmetric: sym set means both send and obey pause.
// - Admin-disabled port passes no traffic until re-enabled.
// - Storm-enabled port drops broadcasts beyond the threshold.
// - Threshold range 500 to 262143, reset 500; storm control on at reset.
// - Only broadcasts are counted and dropped, never IP multicast.
// - One shared threshold, per-port storm enables.
// - Mirror copies source to target; no direction given means both.
// - At most one mirror session at a time.
// - Session accepted only if both ports in 1-12 or both in 13-24.
// - Session requires matching source and target speeds.
// - Secured port stops learning new source addresses.
// - Secured port accepts only known sources; others flag intrusion.
// - One global intrusion action: none at reset, or disable plus trap.
// - Security-disabled port stays off until admin re-enable.
// - Per-port security enable, off after reset.
// - No security on trunk members; secured port not added to trunk.
// - Secured port may be LACP member, but that trunk stays inactive.
`timescale 1ns/1ns
`default_nettype none
`include "spp_map.vh"
module spp_port_policy #(
  parameter WINDOW_CYC = `SPP_WINDOW_CYC,
  parameter [23:0] FIBRE_MASK = 24'h000000,
  parameter [23:0] FAST_MASK  = 24'h000000
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Negotiated link state per port
  input  wire [23:0] link_up,
  input  wire [47:0] neg_speed,
  input  wire [23:0] neg_duplex,
  input  wire [23:0] neg_pause,
  // Received frame events, one-cycle pulses per port
  input  wire [23:0] rx_frame,
  input  wire [23:0] rx_bcast,
  input  wire [23:0] rx_sa_known,
  // Per-port policy outputs
  output reg  [23:0] port_fwd_en,
  output reg  [23:0] rx_drop,
  output reg  [23:0] learn_en,
  output reg  [119:0] adv_abil,
  output reg  [47:0] oper_speed,
  output reg  [23:0] oper_duplex,
  output reg  [23:0] jam_en,
  output reg  [23:0] pause_tx_en,
  output reg  [23:0] pause_rx_en,
  output reg  [23:0] lacp_allow,
  // Mirror and trap
  output reg         mirror_active,
  output reg  [4:0]  mirror_src,
  output reg  [4:0]  mirror_dst,
  output reg         mirror_rx,
  output reg         mirror_tx,
  output reg         trap_pulse
);

  reg  [23:0] admin_r;
  reg  [23:0] aneg_r;
  reg  [23:0] fc_r;
  reg  [23:0] storm_en_r;
  reg  [17:0] thresh_r;
  reg  [23:0] sec_en_r;
  reg         action_r;
  reg  [12:0] mirror_r;
  reg  [23:0] intrude_r;
  reg  [23:0] trunk_r;
  reg  [23:0] lacp_r;
  reg  [8:0]  pcfg_r [0:23];
  reg  [31:0] win_cnt_r;
  reg         win_tick_r;
  reg  [7:0]  waddr_r;
  reg  [31:0] wdata_r;
  reg         aw_have_r;
  reg         w_have_r;

  wire        wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  wire [7:0]  wa = waddr_r;
  wire        wr_pcfg = wr_fire && wa >= `SPP_OFF_PCFG_BASE &&
                        wa < `SPP_OFF_PCFG_BASE + 8'h60;
  wire [4:0]  wr_idx = wa[6:2] - 5'h10;
  wire [4:0]  m_src = wdata_r[4:0];
  wire [4:0]  m_dst = wdata_r[9:5];

  // Same-group check and speed match for a new mirror session.
  wire src_ok = m_src < 5'd24;
  wire dst_ok = m_dst < 5'd24;
  wire same_grp = (m_src < 5'd12) == (m_dst < 5'd12);
  wire spd_eq = oper_speed[m_src*2 +: 2] == oper_speed[m_dst*2 +: 2];
  wire mir_ok = !wdata_r[`SPP_MIR_EN_BIT] ||
                (src_ok && dst_ok && same_grp && spd_eq && m_src != m_dst);

  // Write channel: address and data accepted in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      waddr_r       <= 8'h00;
      wdata_r       <= 32'h00000000;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready;
      s_axi_wready  <= !w_have_r && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r     <= 1'b1;
        waddr_r       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r     <= 1'b1;
        wdata_r      <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        if (wa == `SPP_OFF_MIRROR && !mir_ok)
          s_axi_bresp <= 2'h2;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
      end
    end
  end

  // Register writes and policy state.
  integer i;
  always @(posedge aclk) begin
    if (!aresetn) begin
      admin_r    <= 24'hffffff;
      aneg_r     <= 24'hffffff;
      fc_r       <= 24'h000000;
      storm_en_r <= 24'hffffff;
      thresh_r   <= `SPP_THR_RST;
      sec_en_r   <= 24'h000000;
      action_r   <= 1'b0;
      mirror_r   <= 13'h0000;
      trunk_r    <= 24'h000000;
      lacp_r     <= 24'h000000;
      for (i = 0; i < 24; i = i + 1) begin
        if (FIBRE_MASK[i])
          pcfg_r[i] <= {4'h0, `SPP_ADV_FIBRE_GIG};
        else if (FAST_MASK[i])
          pcfg_r[i] <= {4'h0, `SPP_ADV_COPPER_100};
        else
          pcfg_r[i] <= {4'h0, `SPP_ADV_COPPER_GIG};
      end
    end else begin
      if (wr_fire) begin
        case (wa)
          `SPP_OFF_ADMIN:    admin_r <= wdata_r[23:0];
          `SPP_OFF_ANEG:     aneg_r <= wdata_r[23:0];
          `SPP_OFF_FC:       fc_r <= wdata_r[23:0];
          `SPP_OFF_STORM_EN: storm_en_r <= wdata_r[23:0];
          `SPP_OFF_THRESH: begin
            // Out-of-range values are clamped into the legal span.
            if (wdata_r[31:18] != 14'h0000)
              thresh_r <= `SPP_THR_MAX;
            else if (wdata_r[17:0] < `SPP_THR_MIN)
              thresh_r <= `SPP_THR_MIN;
            else
              thresh_r <= wdata_r[17:0];
          end
          `SPP_OFF_SEC_EN:
            // Trunk members cannot become secured.
            sec_en_r <= wdata_r[23:0] & ~trunk_r;
          `SPP_OFF_ACTION:   action_r <= wdata_r[0];
          `SPP_OFF_MIRROR:
            // A new session replaces the old; only one is held.
            if (mir_ok)
              mirror_r <= wdata_r[12:0];
          `SPP_OFF_TRUNK:
            trunk_r <= wdata_r[23:0] & ~sec_en_r;
          `SPP_OFF_LACP:     lacp_r <= wdata_r[23:0];
          default: begin
            if (wr_pcfg)
              pcfg_r[wr_idx] <= {wdata_r[8:5],
                                 wdata_r[4:0] & `SPP_ADV_MASK};
          end
        endcase
      end
      // A security shutdown clears the admin bit, so only software reopens.
      for (i = 0; i < 24; i = i + 1)
        if (action_r && sec_en_r[i] && rx_frame[i] && !rx_sa_known[i])
          admin_r[i] <= 1'b0;
    end
  end

  // Intrusion sticky flags: hardware set wins over software clear.
  always @(posedge aclk) begin
    if (!aresetn) begin
      intrude_r  <= 24'h000000;
      trap_pulse <= 1'b0;
    end else begin
      trap_pulse <= action_r &&
                    |(sec_en_r & rx_frame & ~rx_sa_known & admin_r);
      intrude_r <= (intrude_r &
                    ~((wr_fire && wa == `SPP_OFF_INTRUDE) ?
                      wdata_r[23:0] : 24'h000000)) |
                   (sec_en_r & rx_frame & ~rx_sa_known);
    end
  end

  // One-second window tick shared by all storm counters.
  always @(posedge aclk) begin
    if (!aresetn) begin
      win_cnt_r  <= 32'h00000000;
      win_tick_r <= 1'b0;
    end else begin
      win_tick_r <= win_cnt_r == WINDOW_CYC - 1;
      if (win_cnt_r == WINDOW_CYC - 1)
        win_cnt_r <= 32'h00000000;
      else
        win_cnt_r <= win_cnt_r + 32'h00000001;
    end
  end

  // Per-port next values are gathered here so that one process owns
  // every output vector instead of 24 processes sharing it bit by bit.
  wire [23:0]  fwd_nxt;
  wire [23:0]  drop_nxt;
  wire [23:0]  learn_nxt;
  wire [119:0] adv_nxt;
  wire [47:0]  spd_nxt;
  wire [23:0]  dpx_nxt;
  wire [23:0]  jam_nxt;
  wire [23:0]  pause_nxt;
  wire [23:0]  lacp_nxt;

  // Per-port policy.
  genvar g;
  generate
    for (g = 0; g < 24; g = g + 1) begin : gen_port
      reg  [17:0] bc_cnt_r;
      wire [1:0]  spd = aneg_r[g] ? neg_speed[g*2 +: 2] :
                        pcfg_r[g][`SPP_SPD_MSB:`SPP_SPD_LSB];
      wire        dpx = aneg_r[g] ? neg_duplex[g] :
                        pcfg_r[g][`SPP_DPX_BIT];
      wire        fc  = aneg_r[g] ? neg_pause[g] : fc_r[g];
      wire        over = bc_cnt_r >= thresh_r;
      wire        bc_drop = storm_en_r[g] && rx_bcast[g] && over;
      wire        sa_bad = sec_en_r[g] && !rx_sa_known[g];
      wire        sym_ok = spd != `SPP_SPD_1000 ||
                           pcfg_r[g][`SPP_SYM_BIT];
      always @(posedge aclk) begin
        if (!aresetn)
          bc_cnt_r <= 18'h00000;
        else if (win_tick_r)
          bc_cnt_r <= 18'h00000;
        else if (rx_frame[g] && rx_bcast[g] && !over)
          bc_cnt_r <= bc_cnt_r + 18'h00001;
      end
      assign fwd_nxt[g]        = admin_r[g] && link_up[g];
      assign drop_nxt[g]       = rx_frame[g] &&
                                 (!admin_r[g] || bc_drop || sa_bad);
      assign learn_nxt[g]      = admin_r[g] && !sec_en_r[g];
      assign adv_nxt[g*5 +: 5] = pcfg_r[g][4:0] & `SPP_ADV_MASK;
      assign spd_nxt[g*2 +: 2] = spd;
      assign dpx_nxt[g]        = dpx;
      assign jam_nxt[g]        = fc && !dpx;
      // Pause is symmetric: both directions follow one enable.
      assign pause_nxt[g]      = fc && dpx && sym_ok;
      assign lacp_nxt[g]       = lacp_r[g] && !sec_en_r[g];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      port_fwd_en <= 24'h000000;
      rx_drop     <= 24'h000000;
      learn_en    <= 24'h000000;
      adv_abil    <= 120'h0;
      oper_speed  <= 48'h000000000000;
      oper_duplex <= 24'h000000;
      jam_en      <= 24'h000000;
      pause_tx_en <= 24'h000000;
      pause_rx_en <= 24'h000000;
      lacp_allow  <= 24'h000000;
    end else begin
      port_fwd_en <= fwd_nxt;
      rx_drop     <= drop_nxt;
      learn_en    <= learn_nxt;
      adv_abil    <= adv_nxt;
      oper_speed  <= spd_nxt;
      oper_duplex <= dpx_nxt;
      jam_en      <= jam_nxt;
      pause_tx_en <= pause_nxt;
      pause_rx_en <= pause_nxt;
      lacp_allow  <= lacp_nxt;
    end
  end

  // Mirror outputs; no direction bits means both directions.
  always @(posedge aclk) begin
    if (!aresetn) begin
      mirror_active <= 1'b0;
      mirror_src    <= 5'h00;
      mirror_dst    <= 5'h00;
      mirror_rx     <= 1'b0;
      mirror_tx     <= 1'b0;
    end else begin
      mirror_active <= mirror_r[`SPP_MIR_EN_BIT];
      mirror_src    <= mirror_r[4:0];
      mirror_dst    <= mirror_r[9:5];
      mirror_rx     <= mirror_r[10] || !mirror_r[11];
      mirror_tx     <= mirror_r[11] || !mirror_r[10];
    end
  end

  // Read channel.
  reg [31:0] rd_val;
  wire [4:0] rd_idx = s_axi_araddr[6:2] - 5'h10;
  always @* begin
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      `SPP_OFF_ADMIN:    rd_val = {8'h00, admin_r};
      `SPP_OFF_ANEG:     rd_val = {8'h00, aneg_r};
      `SPP_OFF_FC:       rd_val = {8'h00, fc_r};
      `SPP_OFF_STORM_EN: rd_val = {8'h00, storm_en_r};
      `SPP_OFF_THRESH:   rd_val = {14'h0000, thresh_r};
      `SPP_OFF_SEC_EN:   rd_val = {8'h00, sec_en_r};
      `SPP_OFF_ACTION:   rd_val = {31'h00000000, action_r};
      `SPP_OFF_MIRROR:   rd_val = {19'h00000, mirror_r};
      `SPP_OFF_STATUS:   rd_val = {8'h00, port_fwd_en};
      `SPP_OFF_INTRUDE:  rd_val = {8'h00, intrude_r};
      `SPP_OFF_TRUNK:    rd_val = {8'h00, trunk_r};
      `SPP_OFF_LACP:     rd_val = {8'h00, lacp_r};
      default: begin
        if (s_axi_araddr >= `SPP_OFF_PCFG_BASE &&
            s_axi_araddr < `SPP_OFF_PCFG_BASE + 8'h60)
          rd_val = {23'h000000, pcfg_r[rd_idx]};
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [verif/spp_policy_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module spp_policy_props (
  // Clock, reset and bus handshakes
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Port events and policy
  input wire logic [23:0] rx_frame,
  input wire logic [23:0] rx_sa_known,
  input wire logic [23:0] rx_drop,
  input wire logic [47:0] oper_speed,
  input wire logic [23:0] jam_en,
  input wire logic [23:0] pause_tx_en,
  input wire logic [23:0] pause_rx_en,
  input wire logic        mirror_active,
  input wire logic [4:0]  mirror_src,
  input wire logic [4:0]  mirror_dst,
  input wire logic        mirror_rx,
  input wire logic        mirror_tx,
  input wire logic        trap_pulse
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rd_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  jam_pause_a: assert property ((jam_en & pause_tx_en) == 24'h0)
    else $error("jam and pause together");
  pause_sym_a: assert property (pause_tx_en == pause_rx_en)
    else $error("pause not symmetric");
  mirror_group_a: assert property (mirror_active |->
    (mirror_src < 5'd12) == (mirror_dst < 5'd12) && mirror_src != mirror_dst)
    else $error("mirror ports in different groups");
  mirror_speed_a: assert property (mirror_active |->
    oper_speed[mirror_src*2 +: 2] == oper_speed[mirror_dst*2 +: 2])
    else $error("mirror speeds differ");
  mirror_dir_a: assert property (mirror_active |-> mirror_rx || mirror_tx)
    else $error("mirror copies nothing");
  drop_cause_a: assert property ((rx_drop & ~$past(rx_frame)) == 24'h0)
    else $error("drop without frame");
  trap_cause_a: assert property (trap_pulse |->
    $past(|(rx_frame & ~rx_sa_known)))
    else $error("trap without intrusion");
endmodule
bind spp_port_policy spp_policy_props spp_policy_props_inst (.*);
`default_nettype wire

// [verif/spp_link_partner.sv]
`timescale 1ns/1ns
`default_nettype none
module spp_link_partner (
  // Clock, reset and bench request
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        send,
  input  wire logic [4:0]  port,
  input  wire logic        bcast,
  input  wire logic        known,
  // Link state and frame events
  output var  logic [23:0] link_up,
  output var  logic [47:0] neg_speed,
  output var  logic [23:0] neg_duplex,
  output var  logic [23:0] neg_pause,
  output var  logic [23:0] rx_frame,
  output var  logic [23:0] rx_bcast,
  output var  logic [23:0] rx_sa_known
);
  // Every partner links at gigabit full duplex with pause.
  assign link_up    = 24'hffffff;
  assign neg_speed  = {24{2'h2}};
  assign neg_duplex = 24'hffffff;
  assign neg_pause  = 24'hffffff;
  // Qualifiers flip between frames so a stale value never helps the design.
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_frame    <= 24'h0;
      rx_bcast    <= 24'h0;
      rx_sa_known <= 24'h0;
    end else begin
      rx_frame    <= send ? 24'h1 << port : 24'h0;
      rx_bcast    <= send ? {24{bcast}} : ~rx_bcast;
      rx_sa_known <= send ? {24{known}} : ~rx_sa_known;
    end
  end
endmodule
`default_nettype wire

// [verif/test_switch_port_policy.sv]
`timescale 1ns/1ns
`default_nettype none
module test_switch_port_policy;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        send = 1'b0, bcast = 1'b0, known = 1'b0;
  logic [4:0]  port = 5'h00;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [23:0]  link_up, neg_duplex, neg_pause, rx_frame, rx_bcast;
  wire [23:0]  rx_sa_known, port_fwd_en, rx_drop, learn_en, oper_duplex;
  wire [23:0]  jam_en, pause_tx_en, pause_rx_en, lacp_allow;
  wire [47:0]  neg_speed, oper_speed;
  wire [119:0] adv_abil;
  wire [4:0]   mirror_src, mirror_dst;
  wire         mirror_active, mirror_rx, mirror_tx, trap_pulse;
  int          num_errors = 0, checked = 0, i, x;
  int          adm[24], st[24], sec[24], bc[24];
  int          thr = 500, act = 0;
  logic [1:0]  r;
  spp_port_policy #(.WINDOW_CYC(8000), .FIBRE_MASK(24'h800000),
    .FAST_MASK(24'h000002)) spp_port_policy_inst (.*);
  spp_link_partner spp_link_partner_inst (.*);
  always #25 aclk = ~aclk;
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 99) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 99);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffffffff);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 99);
    cmp(s_axi_rdata & m, e);
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  // The model decides the drop before counting, so frame thr is the first loss.
  task automatic frm(input int p, input logic b, input logic k);
    logic e, t;
    e = !adm[p] || (b && st[p] && bc[p] >= thr) || (sec[p] && !k);
    t = adm[p] && sec[p] && !k && act;
    if (b) bc[p]++;
    if (t) adm[p] = 0;
    @(posedge aclk);
    send <= 1'b1;
    port <= p[4:0];
    bcast <= b;
    known <= k;
    @(posedge aclk);
    send <= 1'b0;
    @(posedge aclk);
    #1;
    cmp(rx_drop[p], e);
    cmp(trap_pulse, t);
  endtask
  initial begin
    x = $urandom(39315);
    for (i = 0; i < 24; i++) begin
      adm[i] = 1;
      st[i] = 1;
      sec[i] = 0;
      bc[i] = 0;
    end
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(8'h00, 32'hffffff);
    rdc(8'h04, 32'hffffff);
    rdc(8'h0c, 32'hffffff);
    rdc(8'h10, 32'd500);
    rdc(8'h14, 32'h0);
    rdc(8'h18, 32'h0);
    rdc(8'h20, 32'hffffff);
    rdc(8'h40, 32'h1f, 32'h1f);
    rdc(8'h44, 32'h0f, 32'h1f);
    rdc(8'h9c, 32'h10, 32'h1f);
    rdc(8'hfc, 32'h0);
    cmp({adv_abil[119:115], adv_abil[9:0]}, 15'h41ff);
    $display("test reset done");
    wr(8'h10, 32'd100);
    rdc(8'h10, 32'd500);
    wr(8'h10, 32'h3ffff);
    rdc(8'h10, 32'h3ffff);
    x = 500 + $urandom % 1000;
    wr(8'h10, x);
    rdc(8'h10, x);
    wr(8'h10, 32'd500);
    $display("test threshold done");
    wr(8'h0c, 32'hfffff7);
    st[3] = 0;
    for (i = 0; i < 503; i++) frm(2, 1'b1, 1'b1);
    frm(2, 1'b0, 1'b1);
    for (i = 0; i < 502; i++) frm(3, 1'b1, 1'b1);
    repeat (8000) @(posedge aclk);
    for (i = 0; i < 24; i++) bc[i] = 0;
    frm(2, 1'b1, 1'b1);
    $display("test storm done");
    wr(8'h18, 32'h1);
    act = 1;
    wr(8'h14, 32'h20);
    sec[5] = 1;
    frm(5, 1'b0, 1'b1);
    cmp(learn_en[5], 1'b0);
    frm(5, 1'b0, 1'b0);
    repeat (2) @(posedge aclk);
    cmp(port_fwd_en[5], 1'b0);
    rdc(8'h24, 32'h20);
    wr(8'h24, 32'h20);
    rdc(8'h24, 32'h0);
    rdc(8'h00, 32'hffffdf);
    frm(5, 1'b0, 1'b1);
    wr(8'h00, 32'hffffff);
    adm[5] = 1;
    frm(5, 1'b0, 1'b1);
    cmp(port_fwd_en[5], 1'b1);
    wr(8'h28, 32'h80);
    wr(8'h14, 32'ha0);
    rdc(8'h14, 32'h20);
    wr(8'h28, 32'ha0);
    rdc(8'h28, 32'h80);
    wr(8'h2c, 32'h60);
    repeat (2) @(posedge aclk);
    cmp(lacp_allow[6:5], 2'b10);
    $display("test security done");
    wr(8'h1c, 32'h1000 | (12 << 5) | 11);
    cmp(r, 2'h2);
    wr(8'h1c, 32'h1000 | (2 << 5) | 1);
    cmp(r, 2'h0);
    wr(8'h04, 32'hfffff7);
    wr(8'h4c, 32'h20);
    wr(8'h1c, 32'h1000 | (3 << 5) | 2);
    cmp(r, 2'h2);
    repeat (2) @(posedge aclk);
    cmp({mirror_active, mirror_rx, mirror_tx}, 3'h7);
    cmp({mirror_src, mirror_dst}, 10'h022);
    wr(8'h1c, 32'h1400 | (2 << 5) | 1);
    cmp(r, 2'h0);
    repeat (2) @(posedge aclk);
    cmp({mirror_active, mirror_rx, mirror_tx}, 3'h6);
    $display("test mirror done");
    wr(8'h08, 32'h18);
    wr(8'h50, 32'h1f);
    repeat (2) @(posedge aclk);
    cmp({oper_speed[9:6], oper_duplex[3]}, 5'h12);
    cmp({jam_en[4:3], pause_tx_en[4:3]}, 4'h4);
    wr(8'h50, 32'h11f);
    repeat (2) @(posedge aclk);
    cmp({pause_tx_en[4], pause_rx_en[4], jam_en[4]}, 3'h6);
    $display("test flow done");
    end_sim();
  end
endmodule
`default_nettype wire
